/* core/usb_host_pipe_flag_clear_set.v */
// Host pipe flag clear and set ports on an Avalon-MM slave
//
// Contract
// - Clear port ones clear matching pipe flags
// - Set port ones force matching flags high
// - Zero bits leave flags unchanged
// - Clear and set ports read zero
// - Five pipes, each own clear/set port
// - Interrupt pipe clear layout, bit3 unused
// - Isochronous bit6 acts on CRC flag
// - Control/bulk set: setup, fault, busy bits
// - Interrupt/iso set: underflow and fault bits
// - Bit12 and common bits force in all
// - Bit6 forces stall on interrupt, control/bulk
// - Fault flag drops only with error source
// - Flag raises pipe irq only when enabled
`timescale 1ns/10ps
`include "pipe_flag_consts.vh"

module usb_host_pipe_flag_clear_set #(
    parameter NUM_PIPES = 5
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Avalon-MM slave
    input wire [31:0] address,
    input wire read,
    input wire write,
    input wire [3:0] byteenable,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output wire waitrequest,
    // Pipe configuration and hardware flag sources
    input wire [2*NUM_PIPES-1:0] pipeTransferType,
    input wire [16*NUM_PIPES-1:0] pipeHwSet,
    input wire [NUM_PIPES-1:0] busyBankClr,
    input wire [NUM_PIPES-1:0] pipeFaultSrc,
    input wire [16*NUM_PIPES-1:0] pipeIrqEnable,
    // Flag state and interrupts
    output wire [16*NUM_PIPES-1:0] pipeFlags,
    output wire [NUM_PIPES-1:0] pipeIrq,
    output wire irq
);

    // ============================================================
    // Layout helpers
    function [15:0] clrLayout;
        input [1:0] pipe_transfer_type;
        begin
            case (pipe_transfer_type)
                `PF_TYPE_CONTROL: clrLayout = `PF_CLR_CTRL_BULK;
                `PF_TYPE_BULK: clrLayout = `PF_CLR_CTRL_BULK;
                `PF_TYPE_ISO: clrLayout = `PF_CLR_ISO;
                default: clrLayout = `PF_CLR_INTR;
            endcase
        end
    endfunction

    function [15:0] setLayout;
        input [1:0] pipe_transfer_type;
        begin
            case (pipe_transfer_type)
                `PF_TYPE_CONTROL: setLayout = `PF_SET_CTRL_BULK;
                `PF_TYPE_BULK: setLayout = `PF_SET_CTRL_BULK;
                `PF_TYPE_ISO: setLayout = `PF_SET_ISO;
                default: setLayout = `PF_SET_INTR;
            endcase
        end
    endfunction

    function [31:0] laneMask;
        input [3:0] be;
        begin
            laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // ============================================================
    // Bus handshake: one wait cycle, then accept
    reg ackQ;
    wire request;
    wire accept;
    wire wrAccept;
    wire rdAccept;
    wire [31:0] wrBits;

    assign request = read | write;
    assign waitrequest = request & ~ackQ;
    assign accept = request & ackQ;
    assign wrAccept = write & ackQ;
    assign rdAccept = read & ackQ;
    assign wrBits = writedata & laneMask(byteenable);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ackQ <= 1'b0;
        end else if (accept) begin
            ackQ <= 1'b0;
        end else begin
            ackQ <= request;
        end
    end

    // ============================================================
    // Event status and mask
    reg [NUM_PIPES-1:0] evtStatusQ;
    reg [NUM_PIPES-1:0] evtMaskQ;
    reg [NUM_PIPES-1:0] pipeIrqPrevQ;
    wire [NUM_PIPES-1:0] evtRise;
    wire statusRead;

    assign evtRise = pipeIrq & ~pipeIrqPrevQ;
    assign statusRead = rdAccept & (address == `PF_EVT_STATUS);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evtStatusQ <= `PF_EVT_RESET;
            evtMaskQ <= `PF_EVT_RESET;
            pipeIrqPrevQ <= `PF_EVT_RESET;
        end else begin
            pipeIrqPrevQ <= pipeIrq;
            // Read clears, a new rising event still lands
            if (statusRead) begin
                evtStatusQ <= evtRise;
            end else begin
                evtStatusQ <= evtStatusQ | evtRise;
            end
            if (wrAccept && address == `PF_EVT_MASK) begin
                evtMaskQ <= wrBits[NUM_PIPES-1:0];
            end
        end
    end

    assign irq = |(evtStatusQ & evtMaskQ);

    // ============================================================
    // Read data, captured in the wait cycle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readdata <= 32'h00000000;
        end else if (read && !ackQ) begin
            if (address == `PF_EVT_STATUS) begin
                // Include a rise landing now, the clear edge drops it
                readdata <= {{(32-NUM_PIPES){1'b0}},
                    (evtStatusQ | evtRise)};
            end else if (address == `PF_EVT_MASK) begin
                readdata <= {{(32-NUM_PIPES){1'b0}}, evtMaskQ};
            end else begin
                // Clear/set ports and unmapped space read zero
                readdata <= 32'h00000000;
            end
        end
    end

    // ============================================================
    // Per-pipe ports and flag slots
    genvar p;
    generate
        for (p = 0; p < NUM_PIPES; p = p + 1) begin : gPipe
            wire [1:0] pipe_transfer_type;
            wire hitClr;
            wire hitSet;
            wire [15:0] clearMask;
            wire [15:0] forceMask;

            assign pipe_transfer_type = pipeTransferType[2*p+1:2*p];
            assign hitClr = wrAccept &&
                (address == `PF_CLR_BASE + p * `PF_PIPE_STRIDE);
            assign hitSet = wrAccept &&
                (address == `PF_SET_BASE + p * `PF_PIPE_STRIDE);
            // Type sampled at the accepting edge
            assign clearMask = hitClr ?
                (wrBits[15:0] & clrLayout(pipe_transfer_type)) : 16'h0000;
            assign forceMask = hitSet ?
                (wrBits[15:0] & setLayout(pipe_transfer_type)) : 16'h0000;

            pipe_flag_slot uSlot (
                .clk(clk),
                .rst_b(rst_b),
                .clearMask(clearMask),
                .forceMask(forceMask),
                .hwSet(pipeHwSet[16*p+15:16*p]),
                .busyBankClr(busyBankClr[p]),
                .pipeFaultSrc(pipeFaultSrc[p]),
                .irqEnable(pipeIrqEnable[16*p+15:16*p]),
                .flags(pipeFlags[16*p+15:16*p]),
                .pipeIrq(pipeIrq[p])
            );
        end
    endgenerate

endmodule // usb_host_pipe_flag_clear_set

/* inc/pipe_flag_consts.vh */
// Constants for the host pipe flag clear and set ports
`ifndef PIPE_FLAG_CONSTS_VH
`define PIPE_FLAG_CONSTS_VH

// ============================================================
// Address map (byte addresses)
`define PF_CLR_BASE 32'h40020560
`define PF_SET_BASE 32'h40020590
`define PF_PIPE_STRIDE 32'h00000004
`define PF_EVT_STATUS 32'h40020600
`define PF_EVT_MASK 32'h40020604

// ============================================================
// Pipe transfer type codes
`define PF_TYPE_CONTROL 2'h0
`define PF_TYPE_ISO 2'h1
`define PF_TYPE_BULK 2'h2
`define PF_TYPE_INTR 2'h3

// ============================================================
// Flag bit positions
`define PF_BIT_RX_IN 0
`define PF_BIT_TX_OUT 1
`define PF_BIT_SETUP_UNDERFLOW 2
`define PF_BIT_PIPE_FAULT 3
`define PF_BIT_NAK 4
`define PF_BIT_OVERFLOW 5
`define PF_BIT_STALL_CRC 6
`define PF_BIT_SHORT_PKT 7
`define PF_BIT_BUSY_BANK 12

// ============================================================
// Writable bits of each port view
`define PF_CLR_CTRL_BULK 16'h00F7
`define PF_CLR_INTR 16'h00F7
`define PF_CLR_ISO 16'h00F7
`define PF_SET_CTRL_BULK 16'h10FF
`define PF_SET_INTR 16'h10FF
`define PF_SET_ISO 16'h10FF

// ============================================================
// Reset values
`define PF_FLAGS_RESET 16'h0000
`define PF_EVT_RESET 5'h00

`endif

/* core/pipe_flag_slot.v */
// Interrupt status flags and interrupt line of one host pipe
`timescale 1ns/10ps
`include "pipe_flag_consts.vh"

module pipe_flag_slot (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Software strobes, already masked to the pipe's layout
    input wire [15:0] clearMask,
    input wire [15:0] forceMask,
    // Hardware side
    input wire [15:0] hwSet,
    input wire busyBankClr,
    input wire pipeFaultSrc,
    input wire [15:0] irqEnable,
    // Results
    output wire [15:0] flags,
    output wire pipeIrq
);

    reg [15:0] flagsQ;
    reg [15:0] flagsD;
    reg faultSrcPrevQ;
    wire faultSrcFall;

    // ============================================================
    // Flag update
    assign faultSrcFall = faultSrcPrevQ & ~pipeFaultSrc;

    always @* begin
        flagsD = flagsQ & ~clearMask;
        // Fault flag drops only with its error source
        flagsD[`PF_BIT_PIPE_FAULT] = flagsQ[`PF_BIT_PIPE_FAULT] &
            ~faultSrcFall;
        if (busyBankClr) begin
            flagsD[`PF_BIT_BUSY_BANK] = 1'b0;
        end
        // Set terms last, so an event beats a same-cycle clear
        flagsD = flagsD | forceMask | hwSet;
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flagsQ <= `PF_FLAGS_RESET;
            faultSrcPrevQ <= 1'b0;
        end else begin
            flagsQ <= flagsD;
            faultSrcPrevQ <= pipeFaultSrc;
        end
    end

    assign flags = flagsQ;
    assign pipeIrq = |(flagsQ & irqEnable);

endmodule // pipe_flag_slot

/* testbench/pipe_flag_monitor.sv */
// Checker for the pipe flag clear and set ports
`timescale 1ns/10ps
`include "pipe_flag_consts.vh"

module pipe_flag_monitor #(
    parameter NUM_PIPES = 5
) (
    // Watched ports
    input wire clk,
    input wire rst_b,
    input wire [31:0] address,
    input wire read,
    input wire write,
    input wire [3:0] byteenable,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire [16*NUM_PIPES-1:0] pipeHwSet,
    input wire [NUM_PIPES-1:0] pipeFaultSrc,
    input wire [16*NUM_PIPES-1:0] pipeIrqEnable,
    input wire [16*NUM_PIPES-1:0] pipeFlags,
    input wire [NUM_PIPES-1:0] pipeIrq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire wrAcc = write && !waitrequest && byteenable == 4'hF;
    wire clr0 = wrAcc && address == `PF_CLR_BASE;
    wire set0 = wrAcc && address == `PF_SET_BASE;
    // ============================================================
    // Properties
    a_wait_one: assert property ((read || write) && waitrequest
        |=> !waitrequest) else $error("wait not one cycle");
    a_read_zero: assert property (read && !waitrequest
        && address >= `PF_CLR_BASE && address < `PF_SET_BASE + 20
        |-> readdata == 32'h0) else $error("port read not zero");
    a_clear_bits: assert property (clr0 |=>
        (pipeFlags[15:0] & $past(writedata[15:0] & ~pipeHwSet[15:0])
        & 16'h00F7) == 16'h0) else $error("flag not cleared");
    a_set_bits: assert property (set0 |=>
        (pipeFlags[15:0] & $past(writedata[15:0]) & 16'h10FF)
        == ($past(writedata[15:0]) & 16'h10FF)) else $error("not set");
    a_zero_keep: assert property (clr0 |=>
        ((pipeFlags[15:0] ^ $past(pipeFlags[15:0])) & 16'h00F7
        & ~$past(writedata[15:0]) & ~$past(pipeHwSet[15:0])) == 16'h0)
        else $error("flag moved");
    a_fault_drop: assert property ($fell(pipeFlags[3])
        |-> !pipeFaultSrc[0]) else $error("fault flag dropped");
    a_irq_gate: assert property (pipeIrq[0] ==
        |(pipeFlags[15:0] & pipeIrqEnable[15:0])) else $error("irq gate");
    a_hw_wins: assert property (clr0 && pipeHwSet[0]
        |=> pipeFlags[0]) else $error("hardware set lost");
endmodule // pipe_flag_monitor

bind usb_host_pipe_flag_clear_set pipe_flag_monitor #(
    .NUM_PIPES(NUM_PIPES)) i_mon (.clk(clk), .rst_b(rst_b),
    .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pipeHwSet(pipeHwSet),
    .pipeFaultSrc(pipeFaultSrc), .pipeIrqEnable(pipeIrqEnable),
    .pipeFlags(pipeFlags), .pipeIrq(pipeIrq));

/* testbench/usb_host_pipe_flag_clear_set_tb.sv */
// Testbench for the pipe flag clear and set ports
`timescale 1ns/10ps
`include "pipe_flag_consts.vh"

module usb_host_pipe_flag_clear_set_tb;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] address = 32'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hF;
    logic [4:0] busyBankClr = 5'h00;
    logic [9:0] pipeTransferType = 10'h0;
    logic [79:0] pipeHwSet = 80'h0;
    logic [4:0] pipeFaultSrc = 5'h0;
    logic [79:0] pipeIrqEnable = 80'h0;
    wire [31:0] readdata;
    wire waitrequest;
    wire [79:0] pipeFlags;
    wire [4:0] pipeIrq;
    wire irq;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    logic [31:0] rd;
    // Type, pipe, set data, flags after set, clear data, flags after
    logic [68:0] rows [4] = '{
        {2'h0, 3'h0, 16'h10FF, 16'h10FF, 16'hFFFF, 16'h1008},
        {2'h1, 3'h1, 16'h0044, 16'h0044, 16'h0040, 16'h0004},
        {2'h2, 3'h3, 16'hFFFF, 16'h10FF, 16'hFFFF, 16'h1008},
        {2'h3, 3'h4, 16'h00AD, 16'h00AD, 16'h0005, 16'h00A8}};

    always #12.5 clk = ~clk;

    usb_host_pipe_flag_clear_set i_dut (.clk(clk), .rst_b(rst_b),
        .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata),
        .waitrequest(waitrequest), .pipeTransferType(pipeTransferType),
        .pipeHwSet(pipeHwSet), .busyBankClr(busyBankClr),
        .pipeFaultSrc(pipeFaultSrc), .pipeIrqEnable(pipeIrqEnable),
        .pipeFlags(pipeFlags), .pipeIrq(pipeIrq), .irq(irq));

    // ============================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bw(input logic [31:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic br(input logic [31:0] a);
        address <= a;
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // ============================================================
    // Sequence
    initial begin
        logic [1:0] ty;
        logic [2:0] p;
        logic [15:0] sd, se, cd, ce;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk(pipeFlags[79:48], 32'h0);
        for (int i = 0; i < 4; i++) begin
            {ty, p, sd, se, cd, ce} = rows[i];
            pipeTransferType[2*p +: 2] <= ty;
            @(posedge clk);
            bw(`PF_SET_BASE + 4 * p, {16'h0, sd});
            chk({16'h0, pipeFlags[16*p +: 16]}, {16'h0, se});
            br(`PF_SET_BASE + 4 * p);
            chk(rd, 32'h0);
            bw(`PF_CLR_BASE + 4 * p, {16'h0, cd});
            chk({16'h0, pipeFlags[16*p +: 16]}, {16'h0, ce});
            br(`PF_CLR_BASE + 4 * p);
            chk(rd, 32'h0);
        end
        pipeFaultSrc[0] <= 1'b1;
        @(posedge clk);
        pipeFaultSrc[0] <= 1'b0;
        repeat (3) @(posedge clk);
        chk({16'h0, pipeFlags[15:0]}, 32'h1000);
        chk({27'h0, pipeIrq}, 32'h0);
        pipeIrqEnable[15:0] <= 16'h1000;
        repeat (3) @(posedge clk);
        chk({31'h0, pipeIrq[0]}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        bw(`PF_EVT_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        br(`PF_EVT_STATUS);
        chk(rd, 32'h1);
        chk({31'h0, irq}, 32'h0);
        pipeHwSet[0] <= 1'b1;
        fork
            bw(`PF_CLR_BASE, 32'h1);
            begin
                repeat (2) @(posedge clk);
                pipeHwSet[0] <= 1'b0;
            end
        join
        chk({31'h0, pipeFlags[0]}, 32'h1);
        // Lanes off: a set write must change nothing
        byteenable <= 4'h0;
        bw(`PF_SET_BASE, 32'h00000002);
        chk({16'h0, pipeFlags[15:0]}, 32'h1001);
        byteenable <= 4'hF;
        busyBankClr[0] <= 1'b1;
        @(posedge clk);
        busyBankClr[0] <= 1'b0;
        @(posedge clk);
        chk({16'h0, pipeFlags[15:0]}, 32'h0001);
        br(32'h40020700);
        chk(rd, 32'h0);
        finish_test();
    end
endmodule // usb_host_pipe_flag_clear_set_tb
